//--- shared/scu_defines.vh
// Purpose: Shared constants for the card-capable serial channel
// Assumes: Included by bare name from design files
// Notes:   Definitions only; no logic here
`ifndef SCU_DEFINES_VH
`define SCU_DEFINES_VH

// Mode field code that selects 8-bit asynchronous operation
`define SCU_MODE_UART8   3'h5
// Prescaler selector codes for the prescaled source clock
`define SCU_DIV_1        2'h0
`define SCU_DIV_8        2'h1
`define SCU_DIV_32       2'h2
// Terminal counts of the prescaler (divide ratio minus one)
`define SCU_PRE_1        5'h00
`define SCU_PRE_8        5'h07
`define SCU_PRE_32       5'h1f
// Sixteen oversample ticks per bit; half a bit is eight ticks
`define SCU_OS_LAST      4'hf
`define SCU_OS_HALF      4'h7
// Data bits per character, index of the last one
`define SCU_DATA_BITS    8
`define SCU_BIT_LAST     3'h7
// Transmit buffer depth
`define SCU_FIFO_DEPTH   16

`endif

//--- verilog/scu_fifo.v
// Purpose: Synchronous FIFO holding characters waiting for transmission
// Assumes: Single clock, synchronous active-high reset, clock enable
// Notes:   Ready and valid come from flip-flops; depth a power of two
`timescale 1ns/10ps
`default_nettype none

module scu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk_sys,
  input  wire             i_srst,
  input  wire             i_ce,
  input  wire             i_in_valid,
  output reg              o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output reg              o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    rd_ptr_r;
  reg  [AW:0]      cnt_r;
  reg  [AW:0]      cnt_nxt;
  wire             push;
  wire             pop;

  assign push       = i_in_valid & o_in_ready;
  assign pop        = i_out_ready & o_out_valid;
  assign o_out_data = mem[rd_ptr_r];

  // Occupancy after this cycle's push and pop
  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage has no reset; only occupied slots are ever read
  always @(posedge i_clk_sys) begin
    if (i_ce & push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // Pointers and registered flags so full and empty are exact
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      cnt_r       <= {(AW+1){1'b0}};
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_r       <= cnt_nxt;
      o_in_ready  <= (cnt_nxt != DEPTH[AW:0]);
      o_out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end

endmodule

`default_nettype wire

//--- verilog/scu_card_uart.v
// Purpose: Card-capable serial channel, async 8-bit frames with parity
// Assumes: Pins synchronous to i_clk_sys; shared pulled-up card line
// Notes:   Configuration bits are plain ports; no external bit clock
// Summary of operation
// - Channel runs only with 8-bit mode code
// - Exactly one stop bit per character
// - Direct: even parity, true data, LSB first
// - Inverse: odd parity, inverted data, MSB first
// - Bit rate from prescaled clock, 16(n+1)
// - No hardware handshake gating transfers
// - No address-match filtering on received MSB
// - Transmit interrupt on completion when selected
// - Transmit starts with enable and waiting character
// - Receive starts with enable and start bit
// - Transmit interrupt when whole character sent
// - Receive interrupt when buffer loaded
// - Overrun overwrites buffer, no receive interrupt
// - Detect overrun, framing, parity; error sum
// - Parity error on receive drives output low
// - Error signalling delays transmit interrupt half bit
// - Card parity error read at transmit interrupt
// - Inversion on buffer write and read only
// - First bit D0 direct, inverted D7 inverse
`timescale 1ns/10ps
`default_nettype none
`include "scu_defines.vh"

module scu_card_uart #(
  parameter FIFO_DEPTH = `SCU_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  input  wire       i_clk_sys,
  input  wire       i_srst,
  input  wire       i_ce,
  input  wire [2:0] i_mode_sel,
  input  wire [1:0] i_div_sel,
  input  wire [7:0] i_brg,
  input  wire       i_par_odd,
  input  wire       i_data_inv,
  input  wire       i_msb_first,
  input  wire       i_txi_on_done,
  input  wire       i_err_sig_en,
  input  wire       i_tx_en,
  input  wire       i_rx_en,
  input  wire       i_tx_valid,
  input  wire [7:0] i_tx_data,
  input  wire       i_rx_read,
  input  wire       i_err_clr,
  input  wire       i_serial_in_pin,
  output reg        o_serial_out_pin,
  output reg        o_tx_ready,
  output reg        o_tx_buf_empty,
  output reg        o_tx_busy,
  output reg        o_tx_irq,
  output reg        o_card_parity_err,
  output reg  [7:0] o_rx_data,
  output reg        o_rx_full,
  output reg        o_rx_irq,
  output reg        o_overrun_err,
  output reg        o_framing_err,
  output reg        o_parity_err,
  output reg        o_err_sum
);

  localparam TX_IDLE  = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA  = 3'h2;
  localparam TX_PAR   = 3'h3;
  localparam TX_STOP  = 3'h4;
  localparam TX_GUARD = 3'h5;

  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA  = 3'h2;
  localparam RX_PAR   = 3'h3;
  localparam RX_STOP  = 3'h4;
  localparam RX_ESIG  = 3'h5;

  wire       chan_on;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       tx_start;
  wire       pre_tick;
  wire       tick16;
  wire [7:0] tx_wr_data;
  wire [7:0] rx_byte_nxt;
  reg  [4:0] pre_top;
  reg  [4:0] pre_cnt_r;
  reg  [7:0] brg_cnt_r;
  reg  [2:0] tx_st_r;
  reg  [3:0] tx_os_r;
  reg  [2:0] tx_bit_r;
  reg  [7:0] tx_sh_r;
  reg        tx_par_r;
  reg        tx_line_r;
  reg  [2:0] rx_st_r;
  reg  [3:0] rx_os_r;
  reg  [2:0] rx_bit_r;
  reg  [7:0] rx_sh_r;
  reg        rx_par_r;
  reg        err_drv_r;
  reg        rx_load;
  reg        rx_perr;
  reg        rx_ferr;
  reg        tx_done;

  // The channel only runs in the 8-bit asynchronous mode
  assign chan_on = (i_mode_sel == `SCU_MODE_UART8);

  // Data inverted on the way into the buffer, framing bits untouched
  assign tx_wr_data = i_data_inv ? ~i_tx_data : i_tx_data;

  // Start needs enable plus a waiting character; no handshake input
  assign tx_start = chan_on & i_tx_en & fifo_out_valid & (tx_st_r == TX_IDLE);

  scu_fifo #(
    .WIDTH (`SCU_DATA_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) scu_fifo_inst (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_ce        (i_ce),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (tx_wr_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (tx_start),
    .o_out_data  (fifo_out_data)
  );

  // Prescaler terminal count from the source clock select
  always @* begin
    case (i_div_sel)
      `SCU_DIV_1:  pre_top = `SCU_PRE_1;
      `SCU_DIV_8:  pre_top = `SCU_PRE_8;
      `SCU_DIV_32: pre_top = `SCU_PRE_32;
      default:     pre_top = `SCU_PRE_32;
    endcase
  end

  // Compare with >= so a smaller divisor written mid-count cannot stall
  assign pre_tick = (pre_cnt_r >= pre_top);
  assign tick16   = pre_tick & (brg_cnt_r >= i_brg);

  // Internal bit clock only: prescaler then generator, 16 ticks per bit
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      pre_cnt_r <= 5'h00;
      brg_cnt_r <= 8'h00;
    end else if (i_ce) begin
      pre_cnt_r <= pre_tick ? 5'h00 : pre_cnt_r + 5'h01;
      if (pre_tick) begin
        brg_cnt_r <= tick16 ? 8'h00 : brg_cnt_r + 8'h01;
      end
    end
  end

  // Transmitter: start, eight data, parity, one stop, optional guard
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_st_r   <= TX_IDLE;
      tx_os_r   <= 4'h0;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h00;
      tx_par_r  <= 1'b0;
      tx_line_r <= 1'b1;
      tx_done   <= 1'b0;
    end else if (i_ce) begin
      tx_done <= 1'b0;
      if (tx_start) begin
        tx_sh_r   <= fifo_out_data;
        tx_par_r  <= (^fifo_out_data) ^ i_par_odd;
        tx_line_r <= 1'b0;
        tx_os_r   <= 4'h0;
        tx_st_r   <= TX_START;
      end else if (tick16 && tx_st_r != TX_IDLE) begin
        tx_os_r <= tx_os_r + 4'h1;
        case (tx_st_r)
          TX_START: begin
            if (tx_os_r == `SCU_OS_LAST) begin
              tx_line_r <= i_msb_first ? tx_sh_r[7] : tx_sh_r[0];
              tx_bit_r  <= 3'h0;
              tx_st_r   <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (tx_os_r == `SCU_OS_LAST) begin
              if (tx_bit_r == `SCU_BIT_LAST) begin
                tx_line_r <= tx_par_r;
                tx_st_r   <= TX_PAR;
              end else begin
                // Next bit from the selected end of the shifter
                tx_line_r <= i_msb_first ? tx_sh_r[6] : tx_sh_r[1];
                tx_sh_r   <= i_msb_first ? {tx_sh_r[6:0], 1'b0} : {1'b0, tx_sh_r[7:1]};
                tx_bit_r  <= tx_bit_r + 3'h1;
              end
            end
          end
          TX_PAR: begin
            if (tx_os_r == `SCU_OS_LAST) begin
              tx_line_r <= 1'b1;
              tx_st_r   <= TX_STOP;
            end
          end
          TX_STOP: begin
            if (tx_os_r == `SCU_OS_LAST) begin
              if (i_err_sig_en) begin
                tx_st_r <= TX_GUARD;
              end else begin
                tx_done <= 1'b1;
                tx_st_r <= TX_IDLE;
              end
            end
          end
          TX_GUARD: begin
            // Half a bit more lets the card pull its error level first
            if (tx_os_r == `SCU_OS_HALF) begin
              tx_done <= 1'b1;
              tx_st_r <= TX_IDLE;
            end
          end
          default: tx_st_r <= TX_IDLE;
        endcase
      end
    end
  end

  // Received byte in natural order, inverted on the way out if asked
  assign rx_byte_nxt = i_data_inv ? ~rx_sh_r : rx_sh_r;

  // Receiver; every character is kept, whatever its top bit
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_st_r   <= RX_IDLE;
      rx_os_r   <= 4'h0;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_par_r  <= 1'b0;
      err_drv_r <= 1'b0;
      rx_load   <= 1'b0;
      rx_perr   <= 1'b0;
      rx_ferr   <= 1'b0;
    end else if (i_ce) begin
      rx_load <= 1'b0;
      // Own transmission is echoed on the shared line, so it is ignored
      if (rx_st_r == RX_IDLE) begin
        if (chan_on && i_rx_en && !i_serial_in_pin && tx_st_r == TX_IDLE) begin
          rx_st_r <= RX_START;
          rx_os_r <= 4'h0;
        end
      end else if (tick16) begin
        rx_os_r <= rx_os_r + 4'h1;
        case (rx_st_r)
          RX_START: begin
            // Mid-bit recheck rejects glitches on the idle-high line
            if (rx_os_r == `SCU_OS_HALF) begin
              rx_os_r  <= 4'h0;
              rx_bit_r <= 3'h0;
              rx_par_r <= 1'b0;
              rx_st_r  <= i_serial_in_pin ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_os_r == `SCU_OS_LAST) begin
              rx_par_r <= rx_par_r ^ i_serial_in_pin;
              rx_sh_r  <= i_msb_first ? {rx_sh_r[6:0], i_serial_in_pin}
                                      : {i_serial_in_pin, rx_sh_r[7:1]};
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == `SCU_BIT_LAST) begin
                rx_st_r <= RX_PAR;
              end
            end
          end
          RX_PAR: begin
            if (rx_os_r == `SCU_OS_LAST) begin
              rx_perr <= rx_par_r ^ i_serial_in_pin ^ i_par_odd;
              rx_st_r <= RX_STOP;
            end
          end
          RX_STOP: begin
            // Stop bit sampled at its middle; a low stop is a framing error
            if (rx_os_r == `SCU_OS_LAST) begin
              rx_ferr <= ~i_serial_in_pin;
              rx_load <= 1'b1;
              rx_os_r <= 4'h0;
              if (rx_perr && i_err_sig_en) begin
                err_drv_r <= 1'b1;
                rx_st_r   <= RX_ESIG;
              end else begin
                rx_st_r <= RX_IDLE;
              end
            end
          end
          RX_ESIG: begin
            // Hold the line low for one whole bit time
            if (rx_os_r == `SCU_OS_LAST) begin
              err_drv_r <= 1'b0;
              rx_st_r   <= RX_IDLE;
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer, flags and interrupts; hardware set beats clear
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rx_data         <= 8'h00;
      o_rx_full         <= 1'b0;
      o_rx_irq          <= 1'b0;
      o_overrun_err     <= 1'b0;
      o_framing_err     <= 1'b0;
      o_parity_err      <= 1'b0;
      o_err_sum         <= 1'b0;
      o_tx_irq          <= 1'b0;
      o_card_parity_err <= 1'b0;
    end else if (i_ce) begin
      o_rx_irq <= 1'b0;
      o_tx_irq <= 1'b0;
      if (rx_load) begin
        o_rx_data <= rx_byte_nxt;
        o_rx_full <= 1'b1;
        // Overrun keeps the new byte but raises no receive interrupt
        if (o_rx_full && !i_rx_read) begin
          o_overrun_err <= 1'b1;
        end else begin
          o_rx_irq <= 1'b1;
        end
      end else if (i_rx_read) begin
        o_rx_full <= 1'b0;
      end
      if (rx_load && rx_ferr) begin
        o_framing_err <= 1'b1;
      end else if (i_err_clr) begin
        o_framing_err <= 1'b0;
      end
      if (rx_load && rx_perr) begin
        o_parity_err <= 1'b1;
      end else if (i_err_clr) begin
        o_parity_err <= 1'b0;
      end
      if (i_err_clr && !(rx_load && o_rx_full && !i_rx_read)) begin
        o_overrun_err <= 1'b0;
      end
      o_err_sum <= o_overrun_err | o_framing_err | o_parity_err;
      // Interrupt source: completed character or character taken
      if (i_txi_on_done) begin
        o_tx_irq <= tx_done;
      end else begin
        o_tx_irq <= tx_start;
      end
      if (tx_done) begin
        o_card_parity_err <= ~i_serial_in_pin;
      end
    end
  end

  // Pin and status outputs, each from its own flip-flop
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_serial_out_pin <= 1'b1;
      o_tx_ready       <= 1'b0;
      o_tx_buf_empty   <= 1'b1;
      o_tx_busy        <= 1'b0;
    end else if (i_ce) begin
      o_serial_out_pin <= tx_line_r & ~err_drv_r;
      o_tx_ready       <= fifo_in_ready;
      o_tx_buf_empty   <= ~fifo_out_valid;
      o_tx_busy        <= (tx_st_r != TX_IDLE);
    end
  end

endmodule

`default_nettype wire

//--- test/scu_card_assertions.sv
// Purpose: Port-level checks of the card serial channel
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design top; watches its ports only
`timescale 1ns/10ps
`default_nettype none
module scu_card_assertions (
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic [2:0] i_mode_sel,
  input wire logic       i_tx_en,
  input wire logic       i_txi_on_done,
  input wire logic       i_err_sig_en,
  input wire logic       i_serial_in_pin,
  input wire logic       o_serial_out_pin,
  input wire logic       o_tx_busy,
  input wire logic       o_tx_irq,
  input wire logic       o_card_parity_err,
  input wire logic       o_rx_full,
  input wire logic       o_rx_irq,
  input wire logic       o_overrun_err,
  input wire logic       o_framing_err,
  input wire logic       o_parity_err,
  input wire logic       o_err_sum
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Transfers only start in the 8-bit mode with transmit enabled
  mode_gate_a: assert property ((i_mode_sel != 3'b101) [*3] |-> !$rose(o_tx_busy))
    else $error("transmit started outside 8-bit mode");
  tx_en_gate_a: assert property (!i_tx_en [*3] |-> !$rose(o_tx_busy))
    else $error("transmit started while disabled");
  start_low_a: assert property ($rose(o_tx_busy) |-> ##[0:1] !o_serial_out_pin)
    else $error("frame did not open with a low start bit");
  // The stop bit (and any guard) is high before completion is flagged
  stop_bit_a: assert property (o_tx_irq && i_txi_on_done |->
    $past(o_serial_out_pin, 4) && $past(o_serial_out_pin, 12))
    else $error("line not high in the stop bit");
  tx_pulse_a: assert property (o_tx_irq |=> !o_tx_irq)
    else $error("transmit irq longer than one cycle");
  rx_load_a: assert property (o_rx_irq |-> o_rx_full ##1 !o_rx_irq)
    else $error("receive irq without a loaded buffer");
  overrun_a: assert property ($rose(o_overrun_err) |-> !o_rx_irq)
    else $error("receive irq raised on overrun");
  err_sum_a: assert property (1'b1 |=>
    o_err_sum == $past(o_overrun_err | o_framing_err | o_parity_err))
    else $error("error sum does not follow the error flags");
  par_signal_a: assert property ($rose(o_parity_err) && i_err_sig_en |->
    ##[0:2] !o_serial_out_pin)
    else $error("no low error signal after a parity error");
  card_err_a: assert property ($rose(o_tx_irq) && i_txi_on_done |->
    o_card_parity_err == !$past(i_serial_in_pin))
    else $error("card error flag not taken from the line");
  // Main scenarios reached
  cover property (o_tx_irq && i_err_sig_en);
  cover property (o_tx_irq && o_card_parity_err);
  cover property (o_rx_irq);
  cover property ($rose(o_overrun_err));
endmodule
bind scu_card_uart scu_card_assertions scu_card_assertions_inst (
  .i_clk_sys, .i_srst, .i_mode_sel, .i_tx_en, .i_txi_on_done, .i_err_sig_en,
  .i_serial_in_pin, .o_serial_out_pin, .o_tx_busy, .o_tx_irq, .o_card_parity_err,
  .o_rx_full, .o_rx_irq, .o_overrun_err, .o_framing_err, .o_parity_err, .o_err_sum
);
`default_nettype wire

//--- test/scu_card_model.sv
// Purpose: Behavioural card on the shared pulled-up line
// Assumes: Bit time in system clocks given by i_bit_len
// Notes:   Drives only low or releases; bench calls send directly
`timescale 1ns/10ps
`default_nettype none
module scu_card_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_line,
  input  wire logic        i_inverse,
  input  wire logic        i_nack,
  input  wire logic [15:0] i_bit_len,
  output logic             o_drive_low
);
  logic [7:0] last_byte = 8'h00;
  logic       par_ok = 1'b0;
  logic       sending = 1'b0;
  logic [8:0] w;
  int         got_cnt = 0;
  initial o_drive_low = 1'b0;
  // Decoder; its own drive is masked so it never hears itself
  always begin
    @(negedge i_line iff !sending);
    repeat (i_bit_len / 2) @(negedge i_clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (i_bit_len) @(negedge i_clk_sys);
      w[i] = i_line;
    end
    for (int i = 0; i < 8; i++) begin
      last_byte[i_inverse ? 7 - i : i] = w[i] ^ i_inverse;
    end
    par_ok = (^w) == i_inverse;
    got_cnt++;
    // A bit and a quarter low spans the delayed completion sample too,
    // yet ends before the device's mid-start recheck of a false start
    if (i_nack) begin
      sending = 1'b1;
      repeat (i_bit_len) @(negedge i_clk_sys);
      o_drive_low = 1'b1;
      repeat (i_bit_len + i_bit_len / 4) @(negedge i_clk_sys);
      o_drive_low = 1'b0;
      sending = 1'b0;
    end
  end
  // One frame; bad[0] flips parity, bad[1] sends a low stop bit
  task automatic send(input logic [7:0] d, input logic [1:0] bad);
    logic [10:0] f;
    for (int i = 0; i < 8; i++) begin
      f[i + 1] = d[i_inverse ? 7 - i : i] ^ i_inverse;
    end
    f[0] = 1'b0;
    f[9] = ^f[8:1] ^ i_inverse ^ bad[0];
    f[10] = !bad[1];
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
      o_drive_low = !f[i];
      repeat (i_bit_len) @(negedge i_clk_sys);
    end
    o_drive_low = 1'b0;
    sending = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/scu_card_uart_tb_top.sv
// Purpose: Self-checking bench for the card serial channel
// Assumes: Inputs change at the falling clock edge
// Notes:   Tick equals one clock except in the rate test
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  end
module scu_card_uart_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic [2:0] i_mode_sel = 3'b101;
  logic [1:0] i_div_sel = 2'h0;
  logic [7:0] i_brg = 8'h00;
  logic inv = 1'b0;
  logic nack = 1'b0;
  logic i_err_sig_en = 1'b0;
  logic i_ce = 1'b1;
  logic i_txi_on_done = 1'b1;
  logic i_tx_en = 1'b1;
  logic i_rx_en = 1'b1;
  logic i_tx_valid = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic i_rx_read = 1'b0;
  logic i_err_clr = 1'b0;
  logic [15:0] bit_len = 16'h0010;
  logic o_serial_out_pin, o_tx_ready, o_tx_buf_empty, o_tx_busy, o_tx_irq;
  logic o_card_parity_err, o_rx_full, o_rx_irq, o_overrun_err, o_framing_err;
  logic o_parity_err, o_err_sum, drive_low;
  logic [7:0] o_rx_data;
  wire i_serial_in_pin = o_serial_out_pin & !drive_low;
  int num_errors = 0;
  int checked = 0;
  int rx_irqs = 0;
  int low_cyc = 0;
  int cycles = 0;
  scu_card_uart scu_card_uart_inst (
    .i_clk_sys, .i_srst, .i_ce, .i_mode_sel, .i_div_sel, .i_brg,
    .i_par_odd(inv), .i_data_inv(inv), .i_msb_first(inv), .i_txi_on_done,
    .i_err_sig_en, .i_tx_en, .i_rx_en, .i_tx_valid, .i_tx_data, .i_rx_read,
    .i_err_clr, .i_serial_in_pin, .o_serial_out_pin, .o_tx_ready, .o_tx_buf_empty,
    .o_tx_busy, .o_tx_irq, .o_card_parity_err, .o_rx_data, .o_rx_full, .o_rx_irq,
    .o_overrun_err, .o_framing_err, .o_parity_err, .o_err_sum
  );
  scu_card_model scu_card_model_inst (
    .i_clk_sys, .i_line(i_serial_in_pin), .i_inverse(inv), .i_nack(nack),
    .i_bit_len(bit_len), .o_drive_low(drive_low)
  );
  always #12.5 i_clk_sys = ~i_clk_sys;
  // Event counters, sampled where outputs have settled
  always @(negedge i_clk_sys) begin
    if (o_rx_irq === 1'b1) rx_irqs++;
    if (o_serial_out_pin === 1'b0 && o_tx_busy === 1'b0) low_cyc++;
  end
  // Hang guard well above the expected run length
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task pulse_clr;
    i_err_clr = 1'b1;
    i_rx_read = 1'b1;
    cyc(1);
    i_err_clr = 1'b0;
    i_rx_read = 1'b0;
    cyc(1);
  endtask
  // Counts cycles up to the next transmit irq, bounded
  task wait_txi(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (o_tx_irq !== 1'b1 && n < 6000);
  endtask
  task t_tx(input logic v, input logic e, input logic [7:0] d, output int n);
    inv = v;
    i_err_sig_en = e;
    i_tx_data = d;
    i_tx_valid = 1'b1;
    cyc(1);
    i_tx_valid = 1'b0;
    wait_txi(n);
    `CHK("tx irq", 1'b1, o_tx_irq)
    `CHK("card byte", d, scu_card_model_inst.last_byte)
    `CHK("card parity", 1'b1, scu_card_model_inst.par_ok)
    `CHK("card error", nack, o_card_parity_err)
    cyc(40);
  endtask
  task t_conv;
    int n0;
    int n1;
    t_tx(1'b0, 1'b0, 8'h3b, n0);
    t_tx(1'b0, 1'b1, 8'h3b, n1);
    `CHK("guard delay", 8, n1 - n0)
    t_tx(1'b1, 1'b0, 8'hc4, n0);
    nack = 1'b1;
    t_tx(1'b1, 1'b1, 8'h5a, n1);
    nack = 1'b0;
    i_div_sel = 2'h1;
    i_brg = 8'h01;
    bit_len = 16'd256;
    t_tx(1'b0, 1'b0, 8'h81, n0);
    `CHK("bit rate", 1'b1, n0 inside {[2800:2840]})
    i_div_sel = 2'h0;
    i_brg = 8'h00;
    bit_len = 16'h0010;
    $display("Test transmit done");
  endtask
  // Buffer-empty irq source; a freeze before the start must hold it back
  task t_irq_src;
    int n;
    i_txi_on_done = 1'b0;
    i_tx_data = 8'h96;
    i_tx_valid = 1'b1;
    cyc(1);
    i_tx_valid = 1'b0;
    i_ce = 1'b0;
    cyc(50);
    `CHK("frozen", 1'b0, o_tx_busy)
    i_ce = 1'b1;
    wait_txi(n);
    `CHK("irq on take", 1, n)
    cyc(220);
    `CHK("thawed byte", 8'h96, scu_card_model_inst.last_byte)
    i_txi_on_done = 1'b1;
    $display("Test irq source done");
  endtask
  task t_rx(input logic v, input logic [7:0] d);
    int n;
    inv = v;
    n = rx_irqs;
    scu_card_model_inst.send(d, 2'b00);
    cyc(4);
    `CHK("rx data", d, o_rx_data)
    `CHK("rx irq", n + 1, rx_irqs)
    `CHK("rx clean", 1'b0, o_err_sum)
    pulse_clr;
    `CHK("rx read", 1'b0, o_rx_full)
    $display("Test receive done");
  endtask
  task t_rx_err;
    int n;
    inv = 1'b0;
    i_err_sig_en = 1'b1;
    n = low_cyc;
    scu_card_model_inst.send(8'h66, 2'b01);
    cyc(20);
    `CHK("error pulse", 16, low_cyc - n)
    `CHK("parity err", 1'b1, o_parity_err)
    `CHK("err sum", 1'b1, o_err_sum)
    scu_card_model_inst.send(8'h44, 2'b10);
    cyc(4);
    `CHK("framing err", 1'b1, o_framing_err)
    pulse_clr;
    n = rx_irqs;
    scu_card_model_inst.send(8'h11, 2'b00);
    scu_card_model_inst.send(8'h22, 2'b00);
    cyc(4);
    `CHK("overrun", 1'b1, o_overrun_err)
    `CHK("overwrite", 8'h22, o_rx_data)
    `CHK("irq count", n + 1, rx_irqs)
    i_rx_en = 1'b0;
    pulse_clr;
    scu_card_model_inst.send(8'h33, 2'b00);
    cyc(4);
    `CHK("rx gated", 1'b0, o_rx_full)
    `CHK("flags clear", 1'b0, o_err_sum)
    i_rx_en = 1'b1;
    i_err_sig_en = 1'b0;
    $display("Test receive errors done");
  endtask
  // Transmitter held off via i_tx_en low while the FIFO fills
  task t_fifo;
    int n;
    int c;
    inv = 1'b0;
    i_tx_en = 1'b0;
    c = scu_card_model_inst.got_cnt;
    i_tx_valid = 1'b1;
    for (int k = 0; k < 17; k++) begin
      i_tx_data = 8'(k);
      cyc(1);
    end
    i_tx_valid = 1'b0;
    cyc(2);
    `CHK("fifo full", 1'b0, o_tx_ready)
    `CHK("tx held", 1'b0, o_tx_busy)
    i_mode_sel = 3'b000;
    i_tx_en = 1'b1;
    cyc(100);
    `CHK("mode gate", 1'b0, o_tx_busy)
    i_mode_sel = 3'b101;
    for (int k = 0; k < 16; k++) wait_txi(n);
    cyc(20);
    `CHK("frames sent", 16, scu_card_model_inst.got_cnt - c)
    `CHK("last byte", 8'h0f, scu_card_model_inst.last_byte)
    `CHK("drained", 1'b1, o_tx_buf_empty)
    $display("Test fifo done");
  endtask
  initial begin
    cyc(12);
    i_srst = 1'b0;
    cyc(2);
    `CHK("idle line", 1'b1, o_serial_out_pin)
    `CHK("buf empty", 1'b1, o_tx_buf_empty)
    `CHK("ready", 1'b1, o_tx_ready)
    `CHK("no error", 1'b0, o_err_sum)
    $display("Test reset done");
    t_conv;
    t_irq_src;
    t_rx(1'b0, 8'ha5);
    t_rx(1'b1, 8'h3c);
    t_rx_err;
    t_fifo;
    stop_test();
  end
endmodule
`default_nettype wire
